/* core/fbm_status_mailbox.v */
// Host-facing status image, checksum validation and mailbox handshake
// of a fieldbus master.
// Assumes the fieldbus engine and the host register port share sys_clk_i,
// so none of their inputs needs a synchroniser.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fbm_defines.vh"

module fbm_status_mailbox (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [`FBM_ADDR_W-1:0] addr_i,
  input wire [`FBM_DATA_W-1:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  output reg [`FBM_DATA_W-1:0] rd_data_o,
  input wire [`FBM_SLAVES-1:0] cfg_slave_map_i,
  input wire [`FBM_SLAVES-1:0] slave_alive_i,
  input wire [`FBM_DATA_W-1:0] cfg_net_checksum_i,
  input wire [`FBM_DATA_W-1:0] cfg_mod_checksum_i,
  output reg cfg_err_o,
  output reg stop_mode_o,
  output reg [`FBM_SLAVES-1:0] cyclic_enable_o,
  output reg mbx_req_o,
  input wire mbx_take_i,
  input wire [`FBM_MBX_AW-1:0] mbx_rd_addr_i,
  output wire [`FBM_DATA_W-1:0] mbx_rd_data_o,
  input wire resp_wr_i,
  input wire [`FBM_MBX_AW-1:0] resp_addr_i,
  input wire [`FBM_DATA_W-1:0] resp_data_i,
  input wire resp_done_i,
  output reg irq_o
);

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Word addresses seen by the host over the register port:
  //   0x00 status, read only: busy, stop, config error, event bits.
  //   0x04, 0x05 configured-slave map, slaves 0 to 15 then 16 to 31.
  //   0x08, 0x09 exchange map in the same layout.
  //   0x0c, 0x0d network and module checksums, read only.
  //   0x10, 0x11 checksum echo words written back by the host.
  //   0x14 trigger, write only; a write of one posts a request.
  //   0x18 event status, 0x19 event clear, 0x1a event enable.
  //   0x20 to 0x2f request mailbox, write only.
  //   0x30 to 0x3f response mailbox, read only.
  // Reads of unmapped or write-only words return zero.
  // An event and a clear in the same cycle leave the event bit set.
  // A request stays busy until the engine takes it, so a second start
  // written meanwhile is dropped rather than queued.

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [`FBM_SLAVES-1:0] cfg_map_reg;
  reg [`FBM_SLAVES-1:0] xchg_map_reg;
  reg [`FBM_DATA_W-1:0] net_crc_reg;
  reg [`FBM_DATA_W-1:0] mod_crc_reg;
  reg [`FBM_DATA_W-1:0] echo_net_reg;
  reg [`FBM_DATA_W-1:0] echo_mod_reg;
  reg busy_reg;
  reg [`FBM_IRQ_W-1:0] irq_stat_reg;
  reg [`FBM_IRQ_W-1:0] irq_stat_next;
  reg [`FBM_IRQ_W-1:0] irq_en_reg;
  reg [`FBM_IRQ_W-1:0] irq_en_next;
  reg [`FBM_IRQ_W-1:0] irq_event;
  reg [`FBM_DATA_W-1:0] rd_data_next;
  reg [`FBM_DATA_W-1:0] resp_word [0:`FBM_MBX_WORDS-1];
  wire mismatch;
  wire trig_wr;
  wire accept_req;
  wire req_wr;
  wire resp_page;
  wire [`FBM_MBX_WORDS-1:0] resp_sel;
  wire [`FBM_DATA_W-1:0] status_word;
  wire [`FBM_MAP_WORDS*`FBM_DATA_W-1:0] cfg_map_w;
  wire [`FBM_MAP_WORDS*`FBM_DATA_W-1:0] xchg_map_w;

  // ****************************************************************
  // Status image refresh
  // ****************************************************************

  // The image follows the loaded configuration on every clock, whether
  // or not the host uses the mailboxes.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_map_reg <= {`FBM_SLAVES{1'b0}};
      net_crc_reg <= {`FBM_DATA_W{1'b0}};
      mod_crc_reg <= {`FBM_DATA_W{1'b0}};
    end else begin
      cfg_map_reg <= cfg_slave_map_i;
      net_crc_reg <= cfg_net_checksum_i;
      mod_crc_reg <= cfg_mod_checksum_i;
    end
  end

  // Exchange bitmap shows configured slaves alive in cyclic exchange.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      xchg_map_reg <= {`FBM_SLAVES{1'b0}};
    end else if (mismatch) begin
      xchg_map_reg <= {`FBM_SLAVES{1'b0}};
    end else begin
      xchg_map_reg <= cfg_slave_map_i & slave_alive_i;
    end
  end

  // ****************************************************************
  // Configuration validation
  // ****************************************************************

  // Compare the host echo with the live checksums, not the image copy,
  // so a reload is caught in the same cycle the engine sees it.
  assign mismatch = (echo_net_reg != cfg_net_checksum_i) ||
                    (echo_mod_reg != cfg_mod_checksum_i);

  // Stop mode and the error indicator track the comparison; cyclic
  // exchange runs apart from any mailbox activity.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_err_o <= 1'b0;
      stop_mode_o <= 1'b0;
      cyclic_enable_o <= {`FBM_SLAVES{1'b0}};
    end else begin
      cfg_err_o <= mismatch;
      stop_mode_o <= mismatch;
      cyclic_enable_o <= mismatch ? {`FBM_SLAVES{1'b0}} :
                         cfg_slave_map_i;
    end
  end

  // The echo registers hold whatever the host wrote back.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      echo_net_reg <= `FBM_ECHO_RST;
      echo_mod_reg <= `FBM_ECHO_RST;
    end else if (wr_stb_i) begin
      if (addr_i == `FBM_REG_ECHO_NET) begin
        echo_net_reg <= wr_data_i;
      end
      if (addr_i == `FBM_REG_ECHO_MOD) begin
        echo_mod_reg <= wr_data_i;
      end
    end
  end

  // ****************************************************************
  // Mailbox request path
  // ****************************************************************

  assign trig_wr = wr_stb_i && (addr_i == `FBM_REG_TRIGGER);
  // Only a start code while idle is taken; a second request is dropped.
  assign accept_req = trig_wr && (wr_data_i == `FBM_TRIG_START) &&
                      !busy_reg;
  // The upper address bits pick a mailbox page; the compare is made on
  // whole words so both sides carry the same width.
  assign req_wr = wr_stb_i &&
    ({addr_i[`FBM_ADDR_W-1:`FBM_MBX_AW], {`FBM_MBX_AW{1'b0}}} ==
     `FBM_REG_REQ_BASE);
  assign resp_page =
    ({addr_i[`FBM_ADDR_W-1:`FBM_MBX_AW], {`FBM_MBX_AW{1'b0}}} ==
     `FBM_REG_RESP_BASE);

  // Request words written by the host, read back by the engine.
  mbx_word_ram u_req_ram (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(req_wr),
    .wr_addr_i(addr_i[`FBM_MBX_AW-1:0]),
    .wr_data_i(wr_data_i),
    .rd_addr_i(mbx_rd_addr_i),
    .rd_data_o(mbx_rd_data_o)
  );

  // A posted request is offered until the engine takes it. Busy and
  // the offer are one state: the acknowledge event fires on acceptance,
  // before the engine has looked at the request.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      mbx_req_o <= 1'b0;
    end else if (accept_req) begin
      busy_reg <= 1'b1;
      mbx_req_o <= 1'b1;
    end else if (mbx_take_i) begin
      busy_reg <= 1'b0;
      mbx_req_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Mailbox response path
  // ****************************************************************

  // One-hot select of the response word the engine is writing.
  assign resp_sel = {{(`FBM_MBX_WORDS-1){1'b0}}, 1'b1} << resp_addr_i;

  // The engine fills one response word at a time.
  genvar gi;
  generate
    for (gi = 0; gi < `FBM_MBX_WORDS; gi = gi + 1) begin : g_resp
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          resp_word[gi] <= {`FBM_DATA_W{1'b0}};
        end else if (resp_wr_i && resp_sel[gi]) begin
          resp_word[gi] <= resp_data_i;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************

  // Acknowledge on acceptance, new response on done, error on entry.
  // The error event fires only on the first cycle of a mismatch, so a
  // cleared bit stays clear while the echo remains wrong.
  always @* begin
    irq_event = {`FBM_IRQ_W{1'b0}};
    irq_event[`FBM_IRQ_ACK] = accept_req;
    irq_event[`FBM_IRQ_RESP] = resp_done_i;
    irq_event[`FBM_IRQ_CFGERR] = mismatch && !cfg_err_o;
  end

  // A clear in the same cycle as a new event leaves the bit set.
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stb_i && (addr_i == `FBM_REG_IRQ_CLR)) begin
      irq_stat_next = irq_stat_next & ~wr_data_i[`FBM_IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  // The enable mask the host writes takes effect on the same edge as
  // the status, so irq_o never lags a newly enabled pending bit.
  always @* begin
    irq_en_next = irq_en_reg;
    if (wr_stb_i && (addr_i == `FBM_REG_IRQ_EN)) begin
      irq_en_next = wr_data_i[`FBM_IRQ_W-1:0];
    end
  end

  // Sticky status, enable mask and the level interrupt.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= {`FBM_IRQ_W{1'b0}};
      irq_en_reg <= `FBM_IRQ_EN_RST;
      irq_o <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      irq_o <= |(irq_stat_next & irq_en_next);
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************

  assign status_word = {{(`FBM_DATA_W-6){1'b0}}, busy_reg, stop_mode_o,
                        cfg_err_o, irq_stat_reg};
  assign cfg_map_w = cfg_map_reg;
  assign xchg_map_w = xchg_map_reg;

  // Pick the addressed word; unmapped and write-only words read zero.
  always @* begin
    rd_data_next = {`FBM_DATA_W{1'b0}};
    case (addr_i)
      `FBM_REG_STATUS: rd_data_next = status_word;
      `FBM_REG_CFG_MAP: rd_data_next = cfg_map_w[15:0];
      `FBM_REG_CFG_MAP + 8'h01: rd_data_next = cfg_map_w[31:16];
      `FBM_REG_XCHG_MAP: rd_data_next = xchg_map_w[15:0];
      `FBM_REG_XCHG_MAP + 8'h01: rd_data_next = xchg_map_w[31:16];
      `FBM_REG_NET_CRC: rd_data_next = net_crc_reg;
      `FBM_REG_MOD_CRC: rd_data_next = mod_crc_reg;
      `FBM_REG_ECHO_NET: rd_data_next = echo_net_reg;
      `FBM_REG_ECHO_MOD: rd_data_next = echo_mod_reg;
      `FBM_REG_IRQ_STAT: rd_data_next = {{(`FBM_DATA_W-`FBM_IRQ_W){1'b0}},
                                         irq_stat_reg};
      `FBM_REG_IRQ_EN: rd_data_next = {{(`FBM_DATA_W-`FBM_IRQ_W){1'b0}},
                                       irq_en_reg};
      default: begin
        if (resp_page) begin
          rd_data_next = resp_word[addr_i[`FBM_MBX_AW-1:0]];
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= {`FBM_DATA_W{1'b0}};
    end else begin
      rd_data_o <= rd_stb_i ? rd_data_next : {`FBM_DATA_W{1'b0}};
    end
  end

endmodule
`default_nettype wire

/* inc/fbm_defines.vh */
// Constants for the host status and mailbox exchange of a fieldbus master.
// Assumes a 16-bit register port and one 10 MHz clock.
`ifndef FBM_DEFINES_VH
`define FBM_DEFINES_VH

// ****************************************************************
// Sizes
// ****************************************************************
`define FBM_DATA_W 16
`define FBM_ADDR_W 8
`define FBM_SLAVES 32
`define FBM_MAP_WORDS 2
`define FBM_MBX_AW 4
`define FBM_MBX_WORDS 16

// ****************************************************************
// Register word addresses
// ****************************************************************
`define FBM_REG_STATUS 8'h00
`define FBM_REG_CFG_MAP 8'h04
`define FBM_REG_XCHG_MAP 8'h08
`define FBM_REG_NET_CRC 8'h0c
`define FBM_REG_MOD_CRC 8'h0d
`define FBM_REG_ECHO_NET 8'h10
`define FBM_REG_ECHO_MOD 8'h11
`define FBM_REG_TRIGGER 8'h14
`define FBM_REG_IRQ_STAT 8'h18
`define FBM_REG_IRQ_CLR 8'h19
`define FBM_REG_IRQ_EN 8'h1a
`define FBM_REG_REQ_BASE 8'h20
`define FBM_REG_RESP_BASE 8'h30

// ****************************************************************
// Fields, reset values and trigger codes
// ****************************************************************
`define FBM_IRQ_W 3
`define FBM_IRQ_ACK 0
`define FBM_IRQ_RESP 1
`define FBM_IRQ_CFGERR 2
`define FBM_ST_CFGERR 3
`define FBM_ST_STOP 4
`define FBM_ST_BUSY 5
`define FBM_ECHO_RST 16'h0000
`define FBM_IRQ_EN_RST 3'h0
`define FBM_TRIG_START 16'h0001

`endif

/* core/mbx_word_ram.v */
// Small word memory holding one mailbox image.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "fbm_defines.vh"

module mbx_word_ram (
  input wire sys_clk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [`FBM_MBX_AW-1:0] wr_addr_i,
  input wire [`FBM_DATA_W-1:0] wr_data_i,
  input wire [`FBM_MBX_AW-1:0] rd_addr_i,
  output reg [`FBM_DATA_W-1:0] rd_data_o
);

  reg [`FBM_DATA_W-1:0] mem [0:`FBM_MBX_WORDS-1];

  // Writes land in the array; the array itself needs no reset.
  always @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data come out of a register one cycle after the address.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= {`FBM_DATA_W{1'b0}};
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule
`default_nettype wire

/* bench/fbm_status_mailbox_monitor.sv */
// Assertion checker for the host status and mailbox block.
// Assumes one clock and a synchronous active-high reset, bound below.
`timescale 1ns/1ns
`default_nettype none

module fbm_status_mailbox_monitor (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [15:0] wr_data_i,
  input wire wr_stb_i,
  input wire rd_stb_i,
  input wire [15:0] rd_data_o,
  input wire [31:0] cfg_slave_map_i,
  input wire [15:0] cfg_net_checksum_i,
  input wire [15:0] cfg_mod_checksum_i,
  input wire cfg_err_o,
  input wire stop_mode_o,
  input wire [31:0] cyclic_enable_o,
  input wire mbx_req_o,
  input wire mbx_take_i
);
  reg [15:0] echo_net_reg;
  reg [15:0] echo_mod_reg;
  wire mism;

  // Mirror of the echo words, so the compare result is known here.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      echo_net_reg <= 16'h0000;
      echo_mod_reg <= 16'h0000;
    end else if (wr_stb_i) begin
      if (addr_i == 8'h10) echo_net_reg <= wr_data_i;
      if (addr_i == 8'h11) echo_mod_reg <= wr_data_i;
    end
  end

  // Either echo word differing from the live checksum is a mismatch.
  assign mism = (echo_net_reg != cfg_net_checksum_i) ||
    (echo_mod_reg != cfg_mod_checksum_i);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_err_follows_echo:
    assert property (!$past(rst_i) |-> cfg_err_o == $past(mism))
    else $error("config error does not follow the echo compare");
  a_stop_is_err:
    assert property (stop_mode_o == cfg_err_o)
    else $error("stop mode differs from config error");
  a_stop_no_xchg:
    assert property (stop_mode_o |-> cyclic_enable_o == 32'h0)
    else $error("cyclic exchange enabled in stop mode");
  a_run_enable_map:
    assert property (!$past(rst_i) && !stop_mode_o |->
      cyclic_enable_o == $past(cfg_slave_map_i))
    else $error("cyclic enable differs from configured map");
  a_rd_idle_zero:
    assert property (!$past(rd_stb_i) |-> rd_data_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_checksum_read:
    assert property ($past(rd_stb_i) && $past(addr_i[7:1]) == 7'h06 |->
      rd_data_o == ($past(addr_i[0]) ? $past(cfg_mod_checksum_i) :
      $past(cfg_net_checksum_i)))
    else $error("checksum read wrong");
  a_map_word_read:
    assert property ($past(rd_stb_i) && $past(addr_i) == 8'h05 |->
      rd_data_o == $past(cfg_slave_map_i[31:16]))
    else $error("upper configured map word wrong");
  a_req_holds:
    assert property (mbx_req_o && !mbx_take_i |=> mbx_req_o)
    else $error("request dropped before take");
  a_req_drops:
    assert property (mbx_take_i |=> !mbx_req_o)
    else $error("request still pending after take");
  a_req_starts:
    assert property ($past(wr_stb_i) && $past(addr_i) == 8'h14 &&
      $past(wr_data_i) == 16'h0001 && !$past(mbx_req_o) |-> mbx_req_o)
    else $error("start trigger not accepted");
endmodule

bind fbm_status_mailbox fbm_status_mailbox_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
  .rd_data_o(rd_data_o), .cfg_slave_map_i(cfg_slave_map_i),
  .cfg_net_checksum_i(cfg_net_checksum_i),
  .cfg_mod_checksum_i(cfg_mod_checksum_i), .cfg_err_o(cfg_err_o),
  .stop_mode_o(stop_mode_o), .cyclic_enable_o(cyclic_enable_o),
  .mbx_req_o(mbx_req_o), .mbx_take_i(mbx_take_i)
);
`default_nettype wire

/* bench/fbm_engine_model.sv */
// Behavioural fieldbus engine that serves the request mailbox.
// Assumes the block's clock; delay_i sets how slowly it answers.
`timescale 1ns/1ns
`default_nettype none

module fbm_engine_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] delay_i,
  input wire logic req_i,
  input wire logic [15:0] req_word_i,
  output logic take_o,
  output logic [3:0] rd_addr_o,
  output logic resp_wr_o,
  output logic [3:0] resp_addr_o,
  output logic [15:0] resp_data_o,
  output logic resp_done_o
);
  logic [15:0] word;

  // Fetch word 0, take the request, answer with its id word, finish.
  initial begin
    take_o = 1'b0;
    rd_addr_o = 4'hf;
    resp_wr_o = 1'b0;
    resp_addr_o = 4'h0;
    resp_data_o = 16'h5a5a;
    resp_done_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      if (req_i && !rst_i) begin
        repeat (delay_i) @(posedge sys_clk_i);
        rd_addr_o <= 4'h0;
        repeat (2) @(posedge sys_clk_i);
        word = req_word_i;
        take_o <= 1'b1;
        rd_addr_o <= 4'hf;
        @(posedge sys_clk_i);
        take_o <= 1'b0;
        resp_wr_o <= 1'b1;
        resp_addr_o <= 4'h0;
        resp_data_o <= word;
        @(posedge sys_clk_i);
        resp_addr_o <= 4'h1;
        resp_data_o <= ~word;
        @(posedge sys_clk_i);
        resp_wr_o <= 1'b0;
        resp_done_o <= 1'b1;
        @(posedge sys_clk_i);
        resp_done_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/fbm_status_mailbox_bench.sv */
// Self-checking bench for the host status and mailbox block.
// Assumes the engine model and the bound checker compiled before it.
`timescale 1ns/1ns
`default_nettype none

module fbm_status_mailbox_bench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_stb_i = 1'b0;
  logic rd_stb_i = 1'b0;
  logic [31:0] map_i = 32'h8001_2000;
  logic [31:0] alive_i = 32'h0001_2000;
  logic [7:0] delay = 8'd20;
  logic [15:0] net_crc = 16'h1a2b;
  wire [15:0] rd_data_o, req_word, resp_data;
  wire [31:0] cyclic_enable_o;
  wire [3:0] rd_addr, resp_addr;
  wire cfg_err_o, stop_mode_o, mbx_req_o, irq_o, take, resp_wr, resp_done;
  int err_count = 0;
  int tests_run = 0;
  int i;

  fbm_status_mailbox u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o), .cfg_slave_map_i(map_i),
    .slave_alive_i(alive_i), .cfg_net_checksum_i(net_crc),
    .cfg_mod_checksum_i(16'h3c4d), .cfg_err_o(cfg_err_o),
    .stop_mode_o(stop_mode_o), .cyclic_enable_o(cyclic_enable_o),
    .mbx_req_o(mbx_req_o), .mbx_take_i(take), .mbx_rd_addr_i(rd_addr),
    .mbx_rd_data_o(req_word), .resp_wr_i(resp_wr), .resp_addr_i(resp_addr),
    .resp_data_i(resp_data), .resp_done_i(resp_done), .irq_o(irq_o));

  fbm_engine_model u_eng (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .delay_i(delay),
    .req_i(mbx_req_o), .req_word_i(req_word), .take_o(take),
    .rd_addr_o(rd_addr), .resp_wr_o(resp_wr), .resp_data_o(resp_data),
    .resp_addr_o(resp_addr),
    .resp_done_o(resp_done));

  // Clock of 100 ns period.
  always #50 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic flags(input logic [3:0] e);
    chk({28'h0, mbx_req_o, irq_o, stop_mode_o, cfg_err_o}, {28'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_stb_i <= 1'b0;
    #1 chk({16'h0000, rd_data_o}, {16'h0000, e});
  endtask

  task automatic wait_resp;
    for (i = 0; i < 200 && resp_done !== 1'b1; i++) @(posedge sys_clk_i);
    if (i == 200) err_count++;
    cyc(2);
  endtask

  task automatic stop_test;
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence: reset, status image, echo, interrupts, mailbox.
  initial begin
    cyc(3);
    flags(4'h0);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    cyc(2);
    flags(4'h3);
    chk(cyclic_enable_o, 32'h0);
    rd(8'h08, 16'h0000);
    rd(8'h0c, 16'h1a2b);
    rd(8'h0d, 16'h3c4d);
    rd(8'h04, 16'h2000);
    rd(8'h05, 16'h8001);
    rd(8'h00, 16'h001c);
    wr(8'h10, 16'h1a2b);
    wr(8'h11, 16'h3c4d);
    alive_i <= 32'h8000_3000;
    cyc(2);
    flags(4'h0);
    chk(cyclic_enable_o, 32'h8001_2000);
    rd(8'h08, 16'h2000);
    rd(8'h09, 16'h8000);
    rd(8'h10, 16'h1a2b);
    wr(8'h19, 16'h0007);
    wr(8'h1a, 16'h0004);
    rd(8'h18, 16'h0000);
    wr(8'h11, 16'h0000);
    cyc(3);
    flags(4'h7);
    wr(8'h11, 16'h3c4d);
    cyc(3);
    flags(4'h4);
    wr(8'h19, 16'h0004);
    cyc(2);
    flags(4'h0);
    rd(8'h1a, 16'h0004);
    for (i = 0; i < 16; i++) wr(8'h20 + i[7:0], 16'ha500 + i[15:0]);
    wr(8'h1a, 16'h0003);
    wr(8'h14, 16'h0001);
    cyc(1);
    flags(4'hc);
    rd(8'h00, 16'h0021);
    wr(8'h14, 16'h0001);
    wait_resp;
    rd(8'h18, 16'h0003);
    rd(8'h30, 16'ha500);
    rd(8'h31, 16'h5aff);
    flags(4'h4);
    wr(8'h19, 16'h0003);
    wr(8'h14, 16'h0002);
    cyc(2);
    flags(4'h0);
    delay <= 8'd0;
    wr(8'h20, 16'hb600);
    wr(8'h14, 16'h0001);
    wait_resp;
    rd(8'h30, 16'hb600);
    rd(8'h31, 16'h49ff);
    // A new configuration loaded under the host must stop the module.
    @(posedge sys_clk_i);
    net_crc <= 16'h0f0f;
    cyc(2);
    flags(4'h7);
    chk(cyclic_enable_o, 32'h0);
    rd(8'h0c, 16'h0f0f);
    stop_test;
  end

  // The tests take about 150 cycles; give up after 20000.
  initial begin
    #2000000;
    err_count++;
    stop_test;
  end
endmodule
`default_nettype wire
